// ### test_uart_mode_control.sv
// Purpose: Self-checking bench for the serial port mode control
// Assumes: Fixed one wait cycle per access
// Notes: Output lag is one or two cycles (two for transmit and receive data), so checks wait three
`timescale 1ns/1ps
`define CHK(a,b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module test_uart_mode_control;
  logic clk_sys, reset_n, avs_read, avs_write, idle, sleep, ard, txd, brk;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic avs_waitrequest, rxp, ctsp, txp, txoe, rtsp, rtsoe, bco, run, crx, ownc, irq, simp;
  logic crts, cbclk, cts_c, ara, pl0, pl1, stp, hs, bcp, ownr;
  logic [3:0] be;
  int err_total = 0;
  int n_compared = 0;
  umc_mode_control u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(be), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .device_idle(idle), .device_sleep(sleep), .auto_rate_done(ard), .core_tx_data(txd),
    .core_rts(crts), .core_bclk(cbclk), .serial_receive_pin(rxp), .clear_to_send_pin(ctsp),
    .core_run(run), .core_rx_data(crx), .core_cts(cts_c), .core_rts_simplex(simp),
    .core_auto_rate(ara), .core_parity_len_0(pl0), .core_parity_len_1(pl1),
    .core_stop_two(stp), .core_high_speed(hs), .serial_transmit_pin(txp),
    .serial_transmit_oe(txoe), .request_to_send_pin(rtsp), .request_to_send_oe(rtsoe),
    .baud_clock_output_pin(bcp), .baud_clock_output_oe(bco), .pin_owned_rx(ownr),
    .pin_owned_cts(ownc), .irq(irq));
  umc_partner u_far (.clk_sys(clk_sys), .tx(txp), .tx_oe(txoe), .rts(rtsp), .brk(brk),
    .rx(rxp), .cts(ctsp));
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    repeat (3) @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask : rd
  task automatic t_regs;
    rd(4'h0, 32'h0);
    wr(4'h0, 32'hffff);
    rd(4'h0, 32'hbbff);
    `CHK({bco, rtsoe, ownc}, 3'b100)
    wr(4'h0, 32'h0);
    wr(4'h2, 32'hffff);
    rd(4'h2, 32'h0);
  endtask : t_regs
  task automatic t_pins;
    for (int c = 0; c < 4; c++) begin
      wr(4'h0, 32'h8000 | 32'(c << 8));
      `CHK({rtsoe, ownc, bco, txoe}, {c == 1 || c == 2, c == 2, c == 3, 1'b1})
    end
    wr(4'h0, 32'h0);
    `CHK({txoe, rtsoe, bco, ownc}, 4'h0)
  endtask : t_pins
  task automatic t_run;
    idle <= 1'b1;
    wr(4'h0, 32'ha000);
    `CHK(run, 1'b0)
    wr(4'h0, 32'h8800);
    `CHK({run, simp}, 2'b11)
    idle <= 1'b0;
  endtask : t_run
  task automatic t_ir;
    wr(4'h0, 32'h9000);
    `CHK(txp, 1'b0)
    rd(4'hc, 32'h6);
    wr(4'h0, 32'h9008);
    `CHK(txp, 1'b1)
  endtask : t_ir
  task automatic t_loop;
    brk <= 1'b1;
    wr(4'h0, 32'h8040);
    `CHK(crx, 1'b1)
    wr(4'h0, 32'h8000);
    `CHK(crx, 1'b0)
    brk <= 1'b0;
  endtask : t_loop
  task automatic t_wake;
    sleep <= 1'b1;
    wr(4'h8, 32'h3);
    wr(4'h0, 32'h8080);
    `CHK(irq, 1'b0)
    brk <= 1'b1;
    repeat (4) @(posedge clk_sys);
    `CHK(irq, 1'b1)
    brk <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(4'h0, 32'h8000);
    wr(4'h8, 32'h0);
    `CHK(irq, 1'b0)
    wr(4'h4, 32'h1);
    rd(4'h4, 32'h0);
    sleep <= 1'b0;
  endtask : t_wake
  task automatic t_ard;
    wr(4'h0, 32'h8020);
    ard <= 1'b1;
    @(posedge clk_sys);
    ard <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd(4'h0, 32'h8000);
    rd(4'h4, 32'h2);
  endtask : t_ard
  task automatic t_misc;
    be <= 4'h1;
    wr(4'h0, 32'hffff);
    be <= 4'hf;
    rd(4'h0, 32'h80ff);
    wr(4'h0, 32'h8225);
    `CHK({ara, pl1, pl0, stp, hs, ownr, cts_c}, 7'b1101010)
    crts <= 1'b1;
    cbclk <= 1'b1;
    repeat (4) @(posedge clk_sys);
    `CHK({rtsp, cts_c, bcp}, 3'b111)
    crts <= 1'b0;
    cbclk <= 1'b0;
  endtask : t_misc
  task automatic t_reset;
    wr(4'h0, 32'h8300);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK({txoe, bco, rtsp, txp, avs_waitrequest, irq}, 6'b001110)
    reset_n <= 1'b1;
    rd(4'h0, 32'h0);
  endtask : t_reset
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    {reset_n, avs_read, avs_write, idle, sleep, ard, brk} = 7'h0;
    {avs_address, avs_writedata, txd} = {4'h0, 32'h0, 1'b1};
    {be, crts, cbclk} = {4'hf, 1'b0, 1'b0};
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_regs;
    t_pins;
    t_run;
    t_ir;
    t_loop;
    t_wake;
    t_ard;
    t_misc;
    t_reset;
    final_report;
  end
  // Whole run is under two hundred cycles, so this only trips on a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    final_report;
  end
endmodule : test_uart_mode_control

// ### umc_mode_control.sv
// Purpose: Mode register and pin ownership for an asynchronous serial port
// Assumes: All pin inputs synchronous to clk_sys
// Notes: Datapath, baud generator and framing live outside this block
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "umc_params.svh"

module umc_mode_control
  import umc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic device_idle,
  input wire logic device_sleep,
  input wire logic auto_rate_done,
  input wire logic core_tx_data,
  input wire logic core_rts,
  input wire logic core_bclk,
  input wire logic serial_receive_pin,
  input wire logic clear_to_send_pin,
  output logic core_run,
  output logic core_rx_data,
  output logic core_cts,
  output logic core_rts_simplex,
  output logic core_auto_rate,
  output logic core_parity_len_0,
  output logic core_parity_len_1,
  output logic core_stop_two,
  output logic core_high_speed,
  output logic serial_transmit_pin,
  output logic serial_transmit_oe,
  output logic request_to_send_pin,
  output logic request_to_send_oe,
  output logic baud_clock_output_pin,
  output logic baud_clock_output_oe,
  output logic pin_owned_rx,
  output logic pin_owned_cts,
  output logic irq
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] mode_q;
  logic [`UMC_ST_WIDTH-1:0] status_q;
  logic [`UMC_ST_WIDTH-1:0] mask_q;
  logic rx_prev_q;
  logic ack_q;
  logic ir_tx_q;
  logic ir_rx_q;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire req = avs_read | avs_write;
  wire take = req & ack_q;
  wire wr_mode = take & avs_write & (avs_address == `UMC_OFS_MODE);
  wire wr_status = take & avs_write & (avs_address == `UMC_OFS_STATUS);
  wire wr_mask = take & avs_write & (avs_address == `UMC_OFS_MASK);
  wire [15:0] be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [15:0] wmask = be_mask & `UMC_MODE_WMASK;

  wire enable = mode_q[`UMC_BIT_ENABLE];
  wire sleeping = device_sleep;
  wire stopped = device_idle & mode_q[`UMC_BIT_IDLE_STOP];
  wire running = enable & ~stopped & ~sleeping;
  // Codec forced off in 4x mode since pulse timing assumes 16x ticks
  wire ir_on = mode_q[`UMC_BIT_IR_EN] & ~mode_q[`UMC_BIT_HIGH_SPEED];
  wire loopback = mode_q[`UMC_BIT_LOOPBACK];
  umc_pins_t pins;
  assign pins = umc_pins_t'(mode_q[`UMC_BIT_PIN_HI:`UMC_BIT_PIN_LO]);

  wire rx_pin = serial_receive_pin ^ mode_q[`UMC_BIT_RX_INV];
  wire wake_armed = enable & mode_q[`UMC_BIT_WAKE] & sleeping;
  wire wake_fall = wake_armed & rx_prev_q & ~rx_pin;
  wire wake_rise = mode_q[`UMC_BIT_WAKE] & ~rx_prev_q & rx_pin;
  wire rate_clr = auto_rate_done & mode_q[`UMC_BIT_AUTO_RATE];

  // Software write first, hardware clear wins on the same edge
  wire [15:0] mode_w = wr_mode ? ((mode_q & ~wmask) | (avs_writedata[15:0] & wmask)) : mode_q;
  wire [15:0] hc_mask = {8'hff, ~wake_rise, 1'b1, ~rate_clr, 5'h1f};
  wire [15:0] mode_d = mode_w & hc_mask;

  wire [`UMC_ST_WIDTH-1:0] st_set = {rate_clr, wake_fall};
  wire [`UMC_ST_WIDTH-1:0] st_clr = wr_status ? avs_writedata[`UMC_ST_WIDTH-1:0] : '0;
  // Set beats clear so an event in the clearing cycle is kept
  wire [`UMC_ST_WIDTH-1:0] status_d = (status_q & ~st_clr) | st_set;

  // Encoder: plain inversion, zero bits drive the line high; decoder: a low line reads as a one
  wire tx_line = ir_on ? ~core_tx_data : core_tx_data;
  wire rx_src = loopback ? tx_line : rx_pin;
  wire rx_dec = ir_on ? ~rx_src : rx_src;

  logic [31:0] rd_mux;
  always_comb begin
    case (avs_address)
      `UMC_OFS_MODE: rd_mux = {16'h0000, mode_q};
      `UMC_OFS_STATUS: rd_mux = {30'h0, status_q};
      `UMC_OFS_MASK: rd_mux = {30'h0, mask_q};
      `UMC_OFS_LIVE: rd_mux = {29'h0, ir_on, running, rx_pin};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // A fixed wait cycle lets the read mux settle before readdata is sampled
  wire ack_d = req & ~ack_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~ack_d;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_readdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= `UMC_MODE_RESET;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mask_q <= '0;
    end else if (wr_mask) begin
      mask_q <= avs_writedata[`UMC_ST_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_pin;
    end
  end

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  // Built from status_d so a new event reaches the pin with its status bit
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_d & mask_q);
    end
  end

  // ----------------------------------------
  // Infrared path
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ir_tx_q <= 1'b1;
    end else begin
      ir_tx_q <= tx_line;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ir_rx_q <= 1'b1;
    end else begin
      ir_rx_q <= rx_dec;
    end
  end

  // ----------------------------------------
  // Pin ownership
  // ----------------------------------------
  wire own_rts = enable & ((pins == UMC_PINS_RTS) | (pins == UMC_PINS_RTS_CTS));
  wire own_cts = enable & (pins == UMC_PINS_RTS_CTS);
  wire own_bclk = enable & (pins == UMC_PINS_BCLK);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      serial_transmit_pin <= 1'b1;
    end else begin
      serial_transmit_pin <= ir_tx_q;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      serial_transmit_oe <= 1'b0;
    end else begin
      serial_transmit_oe <= enable;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_owned_rx <= 1'b0;
    end else begin
      pin_owned_rx <= enable;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      request_to_send_pin <= 1'b1;
    end else begin
      request_to_send_pin <= core_rts;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      request_to_send_oe <= 1'b0;
    end else begin
      request_to_send_oe <= own_rts;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_owned_cts <= 1'b0;
    end else begin
      pin_owned_cts <= own_cts;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      baud_clock_output_pin <= 1'b0;
      baud_clock_output_oe <= 1'b0;
    end else begin
      baud_clock_output_pin <= core_bclk;
      baud_clock_output_oe <= own_bclk;
    end
  end

  // ----------------------------------------
  // Core controls
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      core_run <= 1'b0;
    end else begin
      core_run <= running;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      core_rx_data <= 1'b1;
    end else begin
      core_rx_data <= ir_rx_q;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      core_cts <= 1'b0;
    end else begin
      core_cts <= own_cts ? clear_to_send_pin : 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      core_rts_simplex <= 1'b0;
    end else begin
      core_rts_simplex <= mode_q[`UMC_BIT_RTS_MODE];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      core_auto_rate <= 1'b0;
    end else begin
      core_auto_rate <= mode_q[`UMC_BIT_AUTO_RATE];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      core_parity_len_0 <= 1'b0;
      core_parity_len_1 <= 1'b0;
    end else begin
      core_parity_len_0 <= mode_q[`UMC_BIT_PARITY_LO];
      core_parity_len_1 <= mode_q[`UMC_BIT_PARITY_HI];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      core_stop_two <= 1'b0;
    end else begin
      core_stop_two <= mode_q[`UMC_BIT_STOP];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      core_high_speed <= 1'b0;
    end else begin
      core_high_speed <= mode_q[`UMC_BIT_HIGH_SPEED];
    end
  end

endmodule : umc_mode_control

// ### umc_mode_control_checker.sv
// Purpose: Port checks for the serial port mode control
// Assumes: One clock, async low reset
// Notes: Mode register is hidden, so outputs are tied to each other
`timescale 1ns/1ps
module umc_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic core_run,
  input wire logic core_cts,
  input wire logic clear_to_send_pin,
  input wire logic serial_transmit_oe,
  input wire logic request_to_send_oe,
  input wire logic baud_clock_output_oe,
  input wire logic pin_owned_rx,
  input wire logic pin_owned_cts
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_run_needs_en: assert property (core_run |-> serial_transmit_oe)
    else $error("core runs with port off");
  a_rx_owned: assert property (pin_owned_rx == serial_transmit_oe)
    else $error("receive ownership differs from enable");
  a_off_release: assert property (!serial_transmit_oe |-> !(request_to_send_oe
    | baud_clock_output_oe | pin_owned_cts)) else $error("pin held while off");
  a_rts_bclk: assert property (!(request_to_send_oe && baud_clock_output_oe))
    else $error("request and baud clock pins both driven");
  a_cts_rts: assert property (pin_owned_cts |-> request_to_send_oe)
    else $error("clear pin owned without request pin");
  a_cts_follow: assert property (core_cts == (pin_owned_cts & $past(clear_to_send_pin)))
    else $error("clear to send path wrong");
  a_wait_pulse: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request not answered");
  c_bclk: cover property (baud_clock_output_oe);
  c_cts: cover property (pin_owned_cts);
  c_write: cover property ($fell(avs_waitrequest) && avs_write);
endmodule : umc_checker
bind umc_mode_control umc_checker u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .core_run(core_run), .core_cts(core_cts), .clear_to_send_pin(clear_to_send_pin),
  .serial_transmit_oe(serial_transmit_oe), .request_to_send_oe(request_to_send_oe),
  .baud_clock_output_oe(baud_clock_output_oe), .pin_owned_rx(pin_owned_rx),
  .pin_owned_cts(pin_owned_cts));

// ### umc_params.svh
// Purpose: Offsets, field positions and reset values for the serial port mode control
// Assumes: 32-bit Avalon-MM word addressing in bytes
// Notes: Definitions only
`ifndef UMC_PARAMS_SVH
`define UMC_PARAMS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define UMC_OFS_MODE 4'h0
`define UMC_OFS_STATUS 4'h4
`define UMC_OFS_MASK 4'h8
`define UMC_OFS_LIVE 4'hc

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define UMC_BIT_ENABLE 15
`define UMC_BIT_IDLE_STOP 13
`define UMC_BIT_IR_EN 12
`define UMC_BIT_RTS_MODE 11
`define UMC_BIT_PIN_HI 9
`define UMC_BIT_PIN_LO 8
`define UMC_BIT_WAKE 7
`define UMC_BIT_LOOPBACK 6
`define UMC_BIT_AUTO_RATE 5
`define UMC_BIT_RX_INV 4
`define UMC_BIT_HIGH_SPEED 3
`define UMC_BIT_PARITY_HI 2
`define UMC_BIT_PARITY_LO 1
`define UMC_BIT_STOP 0
`define UMC_MODE_WMASK 16'hbbff
`define UMC_MODE_RESET 16'h0000

// ----------------------------------------
// Status bits
// ----------------------------------------
`define UMC_ST_WAKE 0
`define UMC_ST_RATE_DONE 1
`define UMC_ST_WIDTH 2

`endif

// ### umc_partner.sv
// Purpose: Far end serial transceiver
// Assumes: Pull-up on the receive line
// Notes: Echoes our transmit line; brk forces a start bit
`timescale 1ns/1ps
module umc_partner (
  input wire logic clk_sys,
  input wire logic tx,
  input wire logic tx_oe,
  input wire logic rts,
  input wire logic brk,
  output logic rx,
  output logic cts
);
  logic echo_q;
  // A released line goes to the pull-up level, never a stale value
  always_ff @(posedge clk_sys) echo_q <= tx_oe ? tx : 1'b1;
  assign rx = brk ? 1'b0 : echo_q;
  always_ff @(posedge clk_sys) cts <= rts;
endmodule : umc_partner

// ### umc_pkg.sv
// Purpose: Types for the serial port mode control
// Assumes: Nothing
// Notes: Constants live in umc_params.svh
package umc_pkg;
  typedef enum logic [1:0] {
    UMC_PINS_TXRX,
    UMC_PINS_RTS,
    UMC_PINS_RTS_CTS,
    UMC_PINS_BCLK
  } umc_pins_t;
endpackage : umc_pkg
